// ===== core/ncs_pkg.sv
package ncs_pkg;
    // Credit counter
    localparam logic [5:0] CREDIT_MAX = 6'h20;
    localparam logic [5:0] CREDIT_ZERO = 6'h00;
    localparam logic [1:0] GRANT_NONE = 2'h0;
    localparam logic [1:0] GRANT_ONE = 2'h1;
    localparam logic [5:0] CREDIT_STEP1 = 6'h01;
    localparam logic [5:0] CREDIT_STEP2 = 6'h02;

    // Beat geometry: two half-beat chunks of eight Dwords each
    localparam int HALF_W = 256;
    localparam int BEAT_W = 512;
    localparam int DW_PER_HALF = 8;
    localparam int DW_PER_BEAT = 16;
    localparam int KEEP_W = 64;
    localparam logic LOWER_HALF = 1'b0;
    localparam logic UPPER_HALF = 1'b1;

    // Traffic classes, used as queue index
    localparam logic CLS_POSTED = 1'b0;
    localparam logic CLS_NONPOSTED = 1'b1;

    // Register map, byte addresses
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_NP_DONE = 12'h008;

    // Control register fields and reset value
    localparam int CTRL_STRADDLE_BIT = 0;
    localparam int CTRL_ADDR_ALIGN_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    // Status register fields
    localparam int STAT_LEVEL_LSB = 0;
    localparam int STAT_STRADDLE_BIT = 8;
    localparam int STAT_PCNT_LSB = 16;
    localparam int STAT_NPCNT_LSB = 24;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ncs_pkg

// ===== core/ncs_request_port.sv
// Overview of operation
// - Posted requests pass Non-Posted ones waiting for credit until the NP queue is full.
// - A Non-Posted request starts only when credit count is above zero.
// - Reset clears the credit counter to zero.
// - Grant without NP delivery adds one (01) or two (10/11), capped at 32.
// - Zero grant subtracts one per NP request delivered, floored at zero.
// - Any other case, grant plus NP delivery included, leaves count unchanged.
// - With credit available, requests leave in link arrival order.
// - When credit returns, older held NP requests go first, then arrival order.
// - Grant is accepted every cycle, regardless of packet position.
// - Current credit count shows on a six-bit output, saturating at 32.
// - Second start in a beat only if the earlier TLP ended by Dword 7.
// - Straddle works only in Dword-aligned mode, never address-aligned mode.
// - Straddle drives keep all ones, last low; boundaries via sideband flags.
// - First start flag on any start; lane 0, or lane 32 after an end.
// - Second start flag only for two starts, at 0 and 32, with first end.
// - First end flag marks an end; four-bit pointer gives last Dword.
// - Second end flag only with the first; pointer then 11 to 15 (code gives 8 to 15).
// - First payload Dword follows its descriptor with no gap.
module ncs_request_port #(
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic nrst,
    // Link side, one half-beat chunk per transfer
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [ncs_pkg::HALF_W-1:0] in_data,
    input wire logic in_sop,
    input wire logic in_eop,
    input wire logic [2:0] in_last_dw,
    input wire logic in_np,
    // User side request stream
    output logic req_tvalid,
    input wire logic req_tready,
    output logic [ncs_pkg::BEAT_W-1:0] req_tdata,
    output logic [ncs_pkg::KEEP_W-1:0] req_tkeep,
    output logic req_tlast,
    output logic [1:0] tlp_start_flags,
    output logic first_start_upper,
    output logic [1:0] tlp_end_flags,
    output logic [3:0] first_end_dword_offset,
    output logic [3:0] second_end_dword_offset,
    // Credit
    input wire logic [1:0] np_credit_grant,
    output logic [5:0] np_credit_level,
    // AXI4-Lite slave
    input wire logic [ncs_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ncs_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int AW = $clog2(DEPTH);
    localparam int SEQ_W = AW + 2;
    localparam int META_W = SEQ_W + 5;

    if (DEPTH < 2 || DEPTH > 64 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("DEPTH must be a power of two from 2 to 64");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [7:0] dw_mask(input logic [2:0] last);
        logic [7:0] m;
        m = 8'h00;
        for (int i = 0; i < ncs_pkg::DW_PER_HALF; i++) begin
            m[i] = (3'(i) <= last);
        end
        return m;
    endfunction : dw_mask

    // Wrap-safe age compare on arrival stamps
    function automatic logic is_older(input logic [SEQ_W-1:0] a, input logic [SEQ_W-1:0] b);
        logic [SEQ_W-1:0] diff;
        diff = a - b;
        return diff[SEQ_W-1];
    endfunction : is_older

    ////////////////////////////////////////////////////////////////////////////
    // Registers: control, queues, credit, output beat

    logic [1:0] ctrl_q;
    logic [5:0] credit_q, credit_d;
    logic [SEQ_W-1:0] seq_q;
    logic [31:0] np_done_q;
    logic cur_act_q, cur_cls_q;
    logic [ncs_pkg::HALF_W-1:0] dat_q [2][DEPTH];
    logic [META_W-1:0] meta_q [2][DEPTH];
    logic [AW-1:0] rd_q [2];
    logic [AW-1:0] wr_q [2];
    logic [AW:0] cnt_q [2];

    // Straddle only counts in Dword-aligned mode
    wire straddle_eff = ctrl_q[ncs_pkg::CTRL_STRADDLE_BIT] & ~ctrl_q[ncs_pkg::CTRL_ADDR_ALIGN_BIT];

    // Queue heads: first and second entry of each class
    logic [META_W-1:0] hm0 [2];
    logic [META_W-1:0] hm1 [2];
    logic [ncs_pkg::HALF_W-1:0] hd0 [2];
    logic [ncs_pkg::HALF_W-1:0] hd1 [2];
    logic [AW:0] avail [2];
    for (genvar c = 0; c < 2; c++) begin : g_head
        assign hm0[c] = meta_q[c][rd_q[c]];
        assign hm1[c] = meta_q[c][AW'(rd_q[c] + 1'b1)];
        assign hd0[c] = dat_q[c][rd_q[c]];
        assign hd1[c] = dat_q[c][AW'(rd_q[c] + 1'b1)];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link side push: each class has its own queue so posted traffic only
    // sits behind stalled non-posted requests once the non-posted queue is full

    wire in_cls = in_np;
    wire [AW:0] depth_full = (AW + 1)'(DEPTH);
    assign in_ready = (cnt_q[in_cls] != depth_full);
    wire in_fire = in_valid & in_ready;

    ////////////////////////////////////////////////////////////////////////////
    // Slot 0: continue the open TLP, or start the oldest eligible one

    wire np_ok0 = (cnt_q[ncs_pkg::CLS_NONPOSTED] != '0) && (credit_q != ncs_pkg::CREDIT_ZERO);
    wire p_ok0 = (cnt_q[ncs_pkg::CLS_POSTED] != '0);
    wire [SEQ_W-1:0] seq_p0 = hm0[ncs_pkg::CLS_POSTED][META_W-1:5];
    wire [SEQ_W-1:0] seq_n0 = hm0[ncs_pkg::CLS_NONPOSTED][META_W-1:5];
    // Older NP wins only with credit; posted passes held NP otherwise
    wire pick_np0 = np_ok0 && (!p_ok0 || is_older(seq_n0, seq_p0));
    wire s0_cls = cur_act_q ? cur_cls_q : pick_np0;
    wire s0_vld = cur_act_q ? (cnt_q[cur_cls_q] != '0) : (p_ok0 | np_ok0);
    wire s0_start = s0_vld & ~cur_act_q;
    wire [META_W-1:0] s0_meta = hm0[s0_cls];
    wire s0_eop = s0_meta[1];
    wire [2:0] s0_last = s0_meta[4:2];

    ////////////////////////////////////////////////////////////////////////////
    // Slot 1: continuation of slot 0, or a straddled second start

    wire s0_np_start = s0_start & (s0_cls == ncs_pkg::CLS_NONPOSTED);
    wire [5:0] credit_left = credit_q - (s0_np_start ? ncs_pkg::CREDIT_STEP1 : ncs_pkg::CREDIT_ZERO);
    wire p_took = s0_vld & (s0_cls == ncs_pkg::CLS_POSTED);
    wire n_took = s0_vld & (s0_cls == ncs_pkg::CLS_NONPOSTED);
    assign avail[0] = cnt_q[0] - (AW + 1)'(p_took);
    assign avail[1] = cnt_q[1] - (AW + 1)'(n_took);
    wire [META_W-1:0] p_next = p_took ? hm1[0] : hm0[0];
    wire [META_W-1:0] n_next = n_took ? hm1[1] : hm0[1];
    wire [ncs_pkg::HALF_W-1:0] pd_next = p_took ? hd1[0] : hd0[0];
    wire [ncs_pkg::HALF_W-1:0] nd_next = n_took ? hd1[1] : hd0[1];
    wire np_ok1 = (avail[1] != '0) && (credit_left != ncs_pkg::CREDIT_ZERO);
    wire p_ok1 = (avail[0] != '0);
    wire pick_np1 = np_ok1 && (!p_ok1 || is_older(n_next[META_W-1:5], p_next[META_W-1:5]));
    wire s1_cont = s0_vld & ~s0_eop;
    // A second start needs slot 0 to end in the lower half, Dword 7 at most
    wire s1_new = s0_vld & s0_eop & straddle_eff & (p_ok1 | np_ok1);
    wire s1_cls = s1_cont ? s0_cls : pick_np1;
    wire s1_vld = s1_cont ? (avail[s0_cls] != '0) : s1_new;
    wire [META_W-1:0] s1_meta = (s1_cls == ncs_pkg::CLS_NONPOSTED) ? n_next : p_next;
    wire [ncs_pkg::HALF_W-1:0] s1_data = (s1_cls == ncs_pkg::CLS_NONPOSTED) ? nd_next : pd_next;
    wire s1_eop = s1_vld & s1_meta[1];
    wire [2:0] s1_last = s1_meta[4:2];
    wire s1_start = s1_new;

    // An open TLP never leaves half a beat empty mid-packet
    wire beat_ok = s0_vld & (s0_eop | s1_vld);
    wire load = beat_ok & (~req_tvalid | req_tready);

    ////////////////////////////////////////////////////////////////////////////
    // Pops and non-posted delivery count

    logic [1:0] pop [2];
    for (genvar c = 0; c < 2; c++) begin : g_pop
        assign pop[c] = load ? (2'((s0_cls == c) ? 1 : 0) + 2'((s1_vld && s1_cls == c) ? 1 : 0)) : 2'h0;
    end
    wire s1_np_start = s1_start & (s1_cls == ncs_pkg::CLS_NONPOSTED);
    wire [1:0] np_deliv = load ? (2'(s0_np_start) + 2'(s1_np_start)) : 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Credit next value; grant sampled every cycle, no packet alignment

    wire [5:0] grant_amt = (np_credit_grant == ncs_pkg::GRANT_ONE) ? ncs_pkg::CREDIT_STEP1 : ncs_pkg::CREDIT_STEP2;
    wire [6:0] credit_sum = {1'b0, credit_q} + {1'b0, grant_amt};
    always_comb begin
        credit_d = credit_q;
        if (np_credit_grant != ncs_pkg::GRANT_NONE && np_deliv == 2'h0) begin
            credit_d = (credit_sum > {1'b0, ncs_pkg::CREDIT_MAX}) ? ncs_pkg::CREDIT_MAX : credit_sum[5:0];
        end else if (np_credit_grant == ncs_pkg::GRANT_NONE && np_deliv != 2'h0) begin
            credit_d = (credit_q > 6'(np_deliv)) ? (credit_q - 6'(np_deliv)) : ncs_pkg::CREDIT_ZERO;
        end
    end

    // Credit counter on the user clock
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            credit_q <= ncs_pkg::CREDIT_ZERO;
        end else begin
            credit_q <= credit_d;
        end
    end
    assign np_credit_level = credit_q;

    ////////////////////////////////////////////////////////////////////////////
    // Queue storage; data words need no reset

    wire [META_W-1:0] in_meta = {seq_q, in_last_dw, in_eop, in_sop};
    always_ff @(posedge clk) begin
        if (in_fire) begin
            dat_q[in_cls][wr_q[in_cls]] <= in_data;
            meta_q[in_cls][wr_q[in_cls]] <= in_meta;
        end
    end

    // Queue pointers and fill counts
    for (genvar c = 0; c < 2; c++) begin : g_ptr
        wire push = in_fire & (in_cls == c);
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                rd_q[c] <= '0;
                wr_q[c] <= '0;
                cnt_q[c] <= '0;
            end else begin
                rd_q[c] <= AW'(rd_q[c] + AW'(pop[c]));
                wr_q[c] <= AW'(wr_q[c] + AW'(push));
                cnt_q[c] <= cnt_q[c] + (AW + 1)'(push) - (AW + 1)'(pop[c]);
            end
        end
    end

    // Arrival stamp per TLP keeps link order across both queues
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            seq_q <= '0;
        end else if (in_fire && in_sop) begin
            seq_q <= seq_q + 1'b1;
        end
    end

    // Open TLP tracking between beats
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cur_act_q <= 1'b0;
            cur_cls_q <= ncs_pkg::CLS_POSTED;
        end else if (load) begin
            cur_act_q <= s1_vld ? ~s1_eop : 1'b0;
            cur_cls_q <= s1_vld ? s1_cls : s0_cls;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output beat composition

    wire [7:0] lo_dw = s0_eop ? dw_mask(s0_last) : 8'hff;
    wire [7:0] hi_dw = s1_vld ? (s1_eop ? dw_mask(s1_last) : 8'hff) : 8'h00;
    wire [15:0] dw_keep = {hi_dw, lo_dw};
    logic [ncs_pkg::KEEP_W-1:0] byte_keep;
    for (genvar i = 0; i < ncs_pkg::DW_PER_BEAT; i++) begin : g_keep
        assign byte_keep[4*i +: 4] = {4{dw_keep[i]}};
    end
    // Chunks pack back to back, payload right after descriptor
    wire [ncs_pkg::BEAT_W-1:0] beat_data = {s1_vld ? s1_data : {ncs_pkg::HALF_W{1'b0}}, hd0[s0_cls]};
    // Start flags and lane of the first start
    wire [1:0] start_f = {s0_start & s1_start, s0_start | s1_start};
    wire start_up = ~s0_start & s1_start;
    // End flags and last-Dword pointers
    wire [1:0] end_f = {s0_eop & s1_eop, s0_eop | s1_eop};
    wire [3:0] end0_off = s0_eop ? {ncs_pkg::LOWER_HALF, s0_last} : {ncs_pkg::UPPER_HALF, s1_last};
    wire [3:0] end1_off = (s0_eop & s1_eop) ? {ncs_pkg::UPPER_HALF, s1_last} : 4'h0;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            req_tvalid <= 1'b0;
            req_tdata <= '0;
            req_tkeep <= '0;
            req_tlast <= 1'b0;
            tlp_start_flags <= 2'h0;
            first_start_upper <= 1'b0;
            tlp_end_flags <= 2'h0;
            first_end_dword_offset <= 4'h0;
            second_end_dword_offset <= 4'h0;
        end else if (load) begin
            req_tvalid <= 1'b1;
            req_tdata <= beat_data;
            req_tkeep <= straddle_eff ? {ncs_pkg::KEEP_W{1'b1}} : byte_keep;
            req_tlast <= ~straddle_eff & end_f[0];
            tlp_start_flags <= start_f;
            first_start_upper <= start_up;
            tlp_end_flags <= end_f;
            first_end_dword_offset <= end0_off;
            second_end_dword_offset <= end1_off;
        end else if (req_tready) begin
            req_tvalid <= 1'b0;
        end
    end

    // Delivered non-posted request tally for software
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            np_done_q <= '0;
        end else begin
            np_done_q <= np_done_q + 32'(np_deliv);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave; address and data latched in either order

    logic aw_hold_q, w_hold_q;
    logic [ncs_pkg::ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
    assign s_axi_wready = ~w_hold_q & ~s_axi_bvalid;
    wire do_write = aw_hold_q & w_hold_q & ~s_axi_bvalid;
    wire wr_ctrl = do_write & (awaddr_q[ncs_pkg::ADDR_W-1:2] == ncs_pkg::ADDR_CTRL[ncs_pkg::ADDR_W-1:2]);
    wire wr_known = wr_ctrl | (awaddr_q[ncs_pkg::ADDR_W-1:2] == ncs_pkg::ADDR_STATUS[ncs_pkg::ADDR_W-1:2])
                  | (awaddr_q[ncs_pkg::ADDR_W-1:2] == ncs_pkg::ADDR_NP_DONE[ncs_pkg::ADDR_W-1:2]);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ncs_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? ncs_pkg::RESP_OKAY : ncs_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Mode bits change take effect at the next beat; software should
    // switch modes only while the stream is idle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= ncs_pkg::CTRL_RESET;
        end else if (wr_ctrl && wstrb_q[0]) begin
            ctrl_q <= wdata_q[1:0];
        end
    end

    // Read decode
    wire [ncs_pkg::ADDR_W-3:0] ridx = s_axi_araddr[ncs_pkg::ADDR_W-1:2];
    wire rd_ctrl = (ridx == ncs_pkg::ADDR_CTRL[ncs_pkg::ADDR_W-1:2]);
    wire rd_stat = (ridx == ncs_pkg::ADDR_STATUS[ncs_pkg::ADDR_W-1:2]);
    wire rd_done = (ridx == ncs_pkg::ADDR_NP_DONE[ncs_pkg::ADDR_W-1:2]);
    logic [31:0] status_word;
    always_comb begin
        status_word = 32'h0;
        status_word[ncs_pkg::STAT_LEVEL_LSB +: 6] = credit_q;
        status_word[ncs_pkg::STAT_STRADDLE_BIT] = straddle_eff;
        status_word[ncs_pkg::STAT_PCNT_LSB +: 7] = 7'(cnt_q[ncs_pkg::CLS_POSTED]);
        status_word[ncs_pkg::STAT_NPCNT_LSB +: 7] = 7'(cnt_q[ncs_pkg::CLS_NONPOSTED]);
    end
    wire [31:0] rd_word = rd_ctrl ? {30'h0, ctrl_q} : rd_stat ? status_word : rd_done ? np_done_q : 32'h0;
    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= ncs_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= (rd_ctrl | rd_stat | rd_done) ? ncs_pkg::RESP_OKAY : ncs_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : ncs_request_port

// ===== sim/ncs_monitor.sv
module ncs_monitor (
    input wire logic clk,
    input wire logic nrst,
    input wire logic req_tvalid,
    input wire logic [1:0] tlp_start_flags,
    input wire logic first_start_upper,
    input wire logic [1:0] tlp_end_flags,
    input wire logic [3:0] first_end_dword_offset,
    input wire logic [3:0] second_end_dword_offset,
    input wire logic [1:0] np_credit_grant,
    input wire logic [5:0] np_credit_level
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////
    // Credit counter steps; unchanged always allowed, a delivery may coincide
    rst_clear_a: assert property (disable iff (1'b0) !nrst |-> np_credit_level == 6'h00)
        else $error("credit not cleared in reset");
    level_cap_a: assert property (np_credit_level <= 6'h20)
        else $error("credit above cap");
    grant_one_a: assert property ($past(np_credit_grant) == 2'h1 |->
        np_credit_level >= $past(np_credit_level) && np_credit_level <= $past(np_credit_level) + 6'h01)
        else $error("bad step for single grant");
    grant_two_a: assert property ($past(np_credit_grant[1]) |-> np_credit_level == $past(np_credit_level) ||
        np_credit_level == (($past(np_credit_level) >= 6'h1f) ? 6'h20 : $past(np_credit_level) + 6'h02))
        else $error("bad step for double grant");
    zero_grant_a: assert property ($past(np_credit_grant) == 2'h0 |->
        np_credit_level <= $past(np_credit_level) && np_credit_level + 6'h02 >= $past(np_credit_level))
        else $error("bad step without grant");
    ////////////////////////////////////////////////////////////////
    // Straddle sideband consistency on valid beats
    sop_pair_a: assert property (req_tvalid && tlp_start_flags[1] |->
        tlp_start_flags[0] && tlp_end_flags[0] && first_end_dword_offset <= 4'h7)
        else $error("second start without early end");
    upper_start_a: assert property (req_tvalid && first_start_upper |->
        tlp_start_flags == 2'h1 && tlp_end_flags[0] && first_end_dword_offset <= 4'h7)
        else $error("upper start without end");
    end_pair_a: assert property (req_tvalid && tlp_end_flags[1] |->
        tlp_end_flags[0] && second_end_dword_offset >= 4'hb)
        else $error("second end malformed");
    cover property (req_tvalid && tlp_start_flags == 2'h3);
    cover property (np_credit_level == 6'h20);
    cover property (req_tvalid && tlp_end_flags == 2'h3);
endmodule : ncs_monitor

bind ncs_request_port ncs_monitor u_mon (.clk, .nrst, .req_tvalid, .tlp_start_flags, .first_start_upper,
    .tlp_end_flags, .first_end_dword_offset, .second_end_dword_offset, .np_credit_grant, .np_credit_level);

// ===== sim/ncs_user_model.sv
module ncs_user_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic stall,
    input wire logic [1:0] grant_cmd,
    output logic req_tready,
    output logic [1:0] np_credit_grant
);
    timeunit 1ns;
    timeprecision 1ps;
    // Registered so both outputs move just after an edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            req_tready <= 1'b0;
            np_credit_grant <= 2'h0;
        end else begin
            req_tready <= !stall; // Slow consumer on command
            np_credit_grant <= grant_cmd;
        end
    end
endmodule : ncs_user_model

// ===== sim/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, nrst = 1'b0, in_valid = 1'b0, in_sop = 1'b1, in_eop = 1'b1, in_np = 1'b0, stall = 1'b0;
    logic [2:0] in_last_dw = 3'h0;
    logic [255:0] in_data = 256'h0;
    logic [1:0] grant_cmd = 2'h0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic in_ready, req_tvalid, req_tready, req_tlast, first_start_upper;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [511:0] req_tdata, bd;
    logic [63:0] req_tkeep, bk;
    logic [1:0] tlp_start_flags, tlp_end_flags, np_credit_grant, s_axi_bresp, s_axi_rresp, rr;
    logic [3:0] first_end_dword_offset, second_end_dword_offset, b1;
    logic [5:0] np_credit_level;
    logic [31:0] s_axi_rdata, rd;
    logic bl;
    int n_fail = 0, samples_checked = 0;
    always #2.5 clk = ~clk;
    ncs_request_port #(.DEPTH(8)) dut (.clk, .nrst, .in_valid, .in_ready, .in_data, .in_sop, .in_eop, .in_last_dw,
        .in_np, .req_tvalid, .req_tready, .req_tdata, .req_tkeep, .req_tlast, .tlp_start_flags, .first_start_upper,
        .tlp_end_flags, .first_end_dword_offset, .second_end_dword_offset, .np_credit_grant, .np_credit_level,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    ncs_user_model partner (.clk, .nrst, .stall, .grant_cmd, .req_tready, .np_credit_grant);
    ////////////////////////////////////////////////////////////////
    task conclude;
        $display("Checks %0d errors %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude
    task chk(input logic [71:0] got, input logic [71:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Single-chunk TLP; valid held until the edge that takes it
    task push(input logic [31:0] tag, input logic [2:0] ld, input logic np);
        in_valid <= 1'b1;
        in_data <= {224'h0, tag};
        in_last_dw <= ld;
        in_np <= np;
        do @(posedge clk); while (in_ready !== 1'b1);
    endtask : push
    task beat(input logic [31:0] tag, input logic [1:0] sf, input logic [1:0] ef, input logic [3:0] o0);
        do @(posedge clk); while (!(req_tvalid === 1'b1 && req_tready === 1'b1));
        bd = req_tdata;
        bk = req_tkeep;
        bl = req_tlast;
        b1 = second_end_dword_offset;
        chk(bd[31:0], tag);
        chk({first_start_upper, tlp_start_flags}, {1'b0, sf});
        chk(tlp_end_flags, ef);
        chk(first_end_dword_offset, o0);
    endtask : beat
    // Trailing edge keeps back-to-back calls from double assigning
    task axw(input logic [11:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask : axw
    task axr(input logic [11:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask : axr
    task gnt(input logic [1:0] g);
        grant_cmd <= g;
        @(posedge clk);
        grant_cmd <= 2'h0;
    endtask : gnt
    ////////////////////////////////////////////////////////////////
    task t_reset;
        chk(np_credit_level, 6'h00);
        axr(ncs_pkg::ADDR_STATUS);
        chk(rd, 32'h0);
        axr(12'h00c);
        chk({rr, rd}, {ncs_pkg::RESP_SLVERR, 32'h0});
    endtask : t_reset
    // NP held at zero credit while a later posted TLP passes
    task t_hold;
        push(32'h1, 3'h3, 1'b1);
        push(32'h2, 3'h5, 1'b0);
        in_valid <= 1'b0;
        beat(32'h2, 2'h1, 2'h1, 4'h5);
        chk({bk, 7'h0, bl}, {64'hffffff, 8'h1});
        repeat (6) @(posedge clk);
        chk(req_tvalid, 1'b0);
        gnt(2'h1);
        beat(32'h1, 2'h1, 2'h1, 4'h3);
        repeat (3) @(posedge clk);
        chk(np_credit_level, 6'h00);
    endtask : t_hold
    task t_credit;
        gnt(2'h1);
        repeat (3) @(posedge clk);
        chk(np_credit_level, 6'h01);
        gnt(2'h2);
        repeat (3) @(posedge clk);
        chk(np_credit_level, 6'h03);
        grant_cmd <= 2'h3;
        repeat (20) @(posedge clk);
        chk(np_credit_level, 6'h20);
        stall <= 1'b1;
        push(32'h3, 3'h3, 1'b1);
        push(32'h4, 3'h4, 1'b0);
        push(32'h5, 3'h3, 1'b1);
        in_valid <= 1'b0;
        stall <= 1'b0;
        beat(32'h3, 2'h1, 2'h1, 4'h3);
        beat(32'h4, 2'h1, 2'h1, 4'h4);
        beat(32'h5, 2'h1, 2'h1, 4'h3);
        repeat (3) @(posedge clk);
        chk(np_credit_level, 6'h20);
        grant_cmd <= 2'h0;
    endtask : t_credit
    // Stalled consumer lets two short TLPs pack into one beat
    task t_strad;
        axw(ncs_pkg::ADDR_CTRL, 32'h3);
        chk(rr, ncs_pkg::RESP_OKAY);
        axr(ncs_pkg::ADDR_STATUS);
        chk(rd, 32'h20);
        axw(ncs_pkg::ADDR_CTRL, 32'h1);
        axr(ncs_pkg::ADDR_STATUS);
        chk({rr, rd}, {ncs_pkg::RESP_OKAY, 32'h120});
        stall <= 1'b1;
        push(32'h10, 3'h5, 1'b0);
        push(32'h11, 3'h5, 1'b0);
        push(32'h12, 3'h7, 1'b0);
        in_valid <= 1'b0;
        stall <= 1'b0;
        beat(32'h10, 2'h1, 2'h1, 4'h5);
        chk({bk, 7'h0, bl}, {64'hffffffffffffffff, 8'h0});
        beat(32'h11, 2'h3, 2'h3, 4'h5);
        chk(b1, 4'hf);
        chk(bd[287:256], 32'h12);
    endtask : t_strad
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        t_reset();
        t_hold();
        t_credit();
        t_strad();
        conclude();
    end
    // Whole run needs well under 2000 cycles
    initial begin
        #20000;
        n_fail++;
        conclude();
    end
endmodule : tb
